// file: design/sdm_pkg.sv
// Package: types and constants of the status display and mode select block
`default_nettype none
package sdm_pkg;
    // Clock and timing
    localparam int SDM_CLK_PERIOD_NS = 20;   // 50 MHz pclk
    localparam int SDM_FLASH_HALF_MS = 250;  // Lamp flash half period
    localparam int SDM_DEBOUNCE_MS   = 10;   // Button must hold this long
    localparam logic [23:0] SDM_FLASH_CYC =
        24'(SDM_FLASH_HALF_MS * 1000000 / SDM_CLK_PERIOD_NS);
    localparam logic [23:0] SDM_DEB_CYC =
        24'(SDM_DEBOUNCE_MS * 1000000 / SDM_CLK_PERIOD_NS);

    // Register byte offsets
    localparam logic [11:0] SDM_CFG0_OFS = 12'h000; // Serial channel 0
    localparam logic [11:0] SDM_CFG1_OFS = 12'h004; // Serial channel 1
    localparam logic [11:0] SDM_CTRL_OFS = 12'h008; // View control
    localparam logic [11:0] SDM_STAT_OFS = 12'h00c; // Status, read only
    localparam int SDM_CFG_W      = 13;  // Writable width of a config reg
    localparam int SDM_CTRL_EXIT  = 0;   // Write 1: back to normal view
    localparam int SDM_STAT_VIEW  = 16;  // Field positions in status
    localparam int SDM_STAT_SW    = 19;
    localparam int SDM_STAT_ILK   = 23;
    localparam int SDM_STAT_LOOP  = 24;
    localparam int SDM_STAT_CAPT  = 25;

    // Mode switch codes
    localparam logic [3:0] SDM_SW_LOOP = 4'h8;

    // Protocol selected per channel
    typedef enum logic [1:0] {
        PROTO_USER = 2'h0,
        PROTO_DED  = 2'h1,
        PROTO_TOOL = 2'h2,
        PROTO_LOOP = 2'h3
    } sdm_proto_t;

    // Displayed view
    typedef enum logic [2:0] {
        V_NORM = 3'b001,
        V_STN  = 3'b010,
        V_SET  = 3'b100
    } sdm_view_t;

    // Per-channel settings, laid out as in the config registers
    typedef struct packed {
        logic [4:0] station; // [12:8]
        logic       aux;     // [7] ch0 modem, ch1 RS-485
        logic       stop2;   // [6]
        logic       even;    // [5]
        logic       par_en;  // [4]
        logic       data8;   // [3]
        logic [2:0] baud;    // [2:0]
    } sdm_chan_cfg_t;

    // Activity from one serial engine
    typedef struct packed {
        logic run;
        logic tx;
        logic rx;
        logic ack;       // Pulse: acknowledge sent
        logic nak;       // Pulse: negative acknowledge sent
        logic proto_err;
        logic serial_io_fault;
    } sdm_chan_in_t;

    // Decoded operating mode
    typedef struct packed {
        sdm_proto_t proto0;
        sdm_proto_t proto1;
        logic       interlock;
        logic       loopback;
        logic       ch1_en;
    } sdm_mode_t;

    // Whole block state
    typedef struct packed {
        logic [15:0]         led;
        sdm_view_t           view;
        logic [3:0]          mode_sw;
        logic                captured;
        sdm_mode_t           mode;
        sdm_chan_cfg_t [1:0] cfg;
        logic [1:0]          ack_on;
        logic [1:0]          nak_on;
        logic                btn_stable;
        logic [23:0]         deb_cnt;
        logic [23:0]         fl_cnt;
        logic                fl_ph;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } sdm_state_t;
endpackage
`default_nettype wire

// file: design/sdm_status_display.sv
// Front-panel lamps, display button views and mode switch decode
// Overview of operation
// - LEDs 0-2: ch0 run, transmit, receive
// - LEDs 8-10: ch1 run, transmit, receive
// - Ack lamp on at ack, nak lamp opposite
// - Error lamp on protocol or serial fault
// - LED 6 lit while modem configured
// - LED 7 flashes during host CPU exchange
// - LED 14 on in RS-485 mode
// - LED 15 flashes on serious fault
// - Each press alternates station and settings views
// - LED 15 on station view, off settings
// - Station numbers on LEDs 0-4, 8-12
// - Station view: LEDs 5-7,13 off, 14 on
// - Settings view: baud codes on 0-2, 8-10
// - Baud code 0..7 maps 300..38400 bps
// - LEDs 3/11 data width, 6/14 stop bits
// - LEDs 4/12 parity on, 5/13 even parity
// - Settings view holds LEDs 7, 15 off
// - Mode switch sampled once after reset
// - Switch 0-1 interlock, 2-7 alone, 8 loopback
// - Interlock: ch1 disabled, follows ch0 settings
// - Stand-alone: channels run independently
//
// The address map and the APB register port were left to the implementer.
`default_nettype none
module sdm_status_display
    import sdm_pkg::*;
#(
    parameter logic [23:0] FLASH_CYC = SDM_FLASH_CYC, // Half flash period
    parameter logic [23:0] DEB_CYC   = SDM_DEB_CYC    // Debounce hold
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire sdm_chan_in_t [1:0] chan_in,
    input  wire logic               host_link_activity,
    input  wire logic               serious_fault,
    input  wire logic               disp_btn,
    input  wire logic [3:0]         mode_sw_in,
    output logic      [15:0]        led,
    output sdm_mode_t               mode
);
    sdm_state_t st;     // Registered state
    sdm_state_t n;      // Next state
    logic       wr_acc; // Write taken this edge
    logic       rd_set; // Setup cycle of any transfer
    logic       exit_wr;// Software return to normal view
    logic       press;  // Debounced press edge

    // Bus phase decode; the access ends on the cycle pready is high
    assign wr_acc  = psel & penable & pwrite & st.pready;
    assign rd_set  = psel & ~penable;
    assign exit_wr = wr_acc & (paddr == SDM_CTRL_OFS)
                     & pwdata[SDM_CTRL_EXIT];

    // Next-state logic for everything the block holds
    always_comb begin
        sdm_chan_cfg_t ec;
        int            b;
        n     = st;
        ec    = '0;
        b     = 0;
        press = 1'b0;

        // Mode switch taken on the first edge after reset only;
        // later switch moves are ignored until the next reset
        if (!st.captured) begin
            n.captured = 1'b1;
            n.mode_sw  = mode_sw_in;
            // Start from all-off so unused fields stay zero
            n.mode     = '0;
            unique case (mode_sw_in)
                4'h0: begin
                    n.mode.proto0    = PROTO_USER;
                    n.mode.proto1    = PROTO_USER;
                    n.mode.interlock = 1'b1;
                end
                4'h1: begin
                    n.mode.proto0    = PROTO_DED;
                    n.mode.proto1    = PROTO_DED;
                    n.mode.interlock = 1'b1;
                end
                4'h2: begin
                    n.mode.proto0 = PROTO_USER;
                    n.mode.proto1 = PROTO_USER;
                end
                4'h3: begin
                    n.mode.proto0 = PROTO_DED;
                    n.mode.proto1 = PROTO_DED;
                end
                4'h4: begin
                    n.mode.proto0 = PROTO_USER;
                    n.mode.proto1 = PROTO_DED;
                end
                4'h5: begin
                    n.mode.proto0 = PROTO_DED;
                    n.mode.proto1 = PROTO_USER;
                end
                4'h6: begin
                    n.mode.proto0 = PROTO_TOOL;
                    n.mode.proto1 = PROTO_USER;
                end
                4'h7: begin
                    n.mode.proto0 = PROTO_TOOL;
                    n.mode.proto1 = PROTO_DED;
                end
                SDM_SW_LOOP: begin
                    n.mode.proto0   = PROTO_LOOP;
                    n.mode.proto1   = PROTO_LOOP;
                    n.mode.loopback = 1'b1;
                end
                // Codes 9-15 have no mode; fall back to the safest one
                default: begin
                    n.mode.interlock = 1'b1;
                end
            endcase
            // Channel 1 is only a data path when not interlocked
            n.mode.ch1_en = ~n.mode.interlock;
        end

        // Debounce: raw level must differ for DEB_CYC cycles in a row
        // Release is filtered too, so bounce on release cannot re-press
        if (disp_btn == st.btn_stable) begin
            n.deb_cnt = '0;
        end else if (st.deb_cnt == DEB_CYC - 24'h000001) begin
            n.deb_cnt    = '0;
            n.btn_stable = disp_btn;
            press        = disp_btn;
        end else begin
            n.deb_cnt = st.deb_cnt + 24'h000001;
        end

        // View sequence: station first, then alternate per press
        // A software exit outranks a press in the same cycle
        if (exit_wr) begin
            n.view = V_NORM;
        end else if (press) begin
            unique case (st.view)
                V_NORM:  n.view = V_STN;
                V_STN:   n.view = V_SET;
                V_SET:   n.view = V_STN;
                default: n.view = V_NORM;
            endcase
        end

        // Flash phase for the blinking lamps
        // One shared phase keeps both flashing lamps in step
        if (st.fl_cnt == FLASH_CYC - 24'h000001) begin
            n.fl_cnt = '0;
            n.fl_ph  = ~st.fl_ph;
        end else begin
            n.fl_cnt = st.fl_cnt + 24'h000001;
        end

        // Acknowledge lamps; a nak in the same cycle wins the pair
        // Sticky: only the opposite pulse turns a lamp off
        for (int c = 0; c < 2; c++) begin
            if (chan_in[c].nak) begin
                n.ack_on[c] = 1'b0;
                n.nak_on[c] = 1'b1;
            end else if (chan_in[c].ack) begin
                n.ack_on[c] = 1'b1;
                n.nak_on[c] = 1'b0;
            end
        end

        // Register writes take effect on the completing edge
        // Other offsets, status included, drop the write
        if (wr_acc && paddr == SDM_CFG0_OFS) begin
            n.cfg[0] = sdm_chan_cfg_t'(pwdata[SDM_CFG_W-1:0]);
        end
        if (wr_acc && paddr == SDM_CFG1_OFS) begin
            n.cfg[1] = sdm_chan_cfg_t'(pwdata[SDM_CFG_W-1:0]);
        end

        // Lamps, built from next state so they move with the view
        for (int c = 0; c < 2; c++) begin
            b = c * 8;
            // Interlocked: channel 1 runs with channel 0 settings
            ec = (c == 1 && n.mode.interlock) ? n.cfg[0] : n.cfg[c];
            unique case (n.view)
                V_STN: begin
                    n.led[b +: 5] = n.cfg[c].station;
                    n.led[b + 5]  = 1'b0;
                    n.led[b + 6]  = (c == 1);
                    n.led[b + 7]  = (c == 1);
                end
                V_SET: begin
                    // Code n selects 300 * 2**n bps; 0 is 76800 on
                    // channel 1 in later firmware, so pass raw code
                    n.led[b +: 3] = ec.baud;
                    n.led[b + 3]  = ec.data8;
                    n.led[b + 4]  = ec.par_en;
                    n.led[b + 5]  = ec.even;
                    n.led[b + 6]  = ec.stop2;
                    n.led[b + 7]  = 1'b0;
                end
                default: begin
                    if (c == 0) begin
                        n.led[0] = chan_in[0].run;
                    end else begin
                        n.led[8] = chan_in[1].run
                                   & n.mode.ch1_en;
                    end
                    n.led[b + 1] = chan_in[c].tx;
                    n.led[b + 2] = chan_in[c].rx;
                    n.led[b + 3] = n.ack_on[c];
                    n.led[b + 4] = n.nak_on[c];
                    n.led[b + 5] = chan_in[c].proto_err
                        | chan_in[c].serial_io_fault;
                    // Ch0: modem selected, ch1: RS-485 selected
                    n.led[b + 6] = n.cfg[c].aux;
                    n.led[b + 7] = (c == 0)
                        ? host_link_activity & n.fl_ph
                        : serious_fault & n.fl_ph;
                end
            endcase
        end

        // Read data is prepared in the setup cycle, one wait-free
        // access follows; unmapped offsets answer with an error
        n.pready  = rd_set;
        n.pslverr = 1'b0;
        n.prdata  = '0;
        if (rd_set) begin
            unique case (paddr)
                SDM_CFG0_OFS: n.prdata[SDM_CFG_W-1:0] = st.cfg[0];
                SDM_CFG1_OFS: n.prdata[SDM_CFG_W-1:0] = st.cfg[1];
                SDM_CTRL_OFS: n.prdata = '0; // Exit bit reads zero
                SDM_STAT_OFS: begin
                    n.prdata[15:0]             = st.led;
                    n.prdata[SDM_STAT_VIEW+:3] = st.view;
                    n.prdata[SDM_STAT_SW+:4]   = st.mode_sw;
                    n.prdata[SDM_STAT_ILK]     = st.mode.interlock;
                    n.prdata[SDM_STAT_LOOP]    = st.mode.loopback;
                    n.prdata[SDM_STAT_CAPT]    = st.captured;
                end
                default: n.pslverr = 1'b1;
            endcase
        end
    end

    // State register; reset takes constants only
    // Clearing the capture flag makes every reset re-read the switch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= '0;
            st.view <= V_NORM;
        end else begin
            st <= n;
        end
    end

    // Outputs straight from the state register
    // No gates after the flops, so no lamp can glitch
    assign led     = st.led;
    assign mode    = st.mode;
    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;

    // Checks on the lamp views, mode capture and button handling
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stn_lamp15: assert property (
        st.view == V_STN |-> st.led[15] && st.led[14])
        else $error("station view lamp 15 or 14 not lit");

    a_set_lamps_off: assert property (
        st.view == V_SET |-> !st.led[7] && !st.led[15])
        else $error("settings view lamp 7 or 15 lit");

    a_stn_blank: assert property (
        st.view == V_STN |-> st.led[7:5] == 3'h0 && !st.led[13])
        else $error("station view unused lamps lit");

    a_stn_value: assert property (
        st.view == V_STN |-> st.led[4:0] == st.cfg[0].station
                             && st.led[12:8] == st.cfg[1].station)
        else $error("station number lamps wrong");

    a_set_baud: assert property (
        st.view == V_SET |-> st.led[2:0] == st.cfg[0].baud
                             && st.led[3] == st.cfg[0].data8)
        else $error("settings lamps wrong for channel 0");

    a_mode_frozen: assert property (
        st.captured && $past(st.captured) |-> $stable(st.mode)
                                              && $stable(st.mode_sw))
        else $error("operating mode changed after capture");

    a_loop_mode: assert property (
        $rose(st.captured) && st.mode_sw == SDM_SW_LOOP
        |-> st.mode.loopback && st.mode.proto1 == PROTO_LOOP)
        else $error("switch 8 did not select loopback");

    a_ilk_ch1_off: assert property (
        st.captured |-> st.mode.ch1_en == !st.mode.interlock)
        else $error("channel 1 enable disagrees with interlock");

    a_ack_lamp: assert property (
        st.view == V_NORM && chan_in[0].ack && !chan_in[0].nak
        ##1 st.view == V_NORM |-> st.led[3] && !st.led[4])
        else $error("ack lamp not set after acknowledge");

    a_err_lamp: assert property (
        st.view == V_NORM && chan_in[1].serial_io_fault
        ##1 st.view == V_NORM |-> st.led[13])
        else $error("channel 1 error lamp not lit");

    a_press_view: assert property (
        $rose(st.btn_stable) && $past(st.view) == V_STN
        && !$past(exit_wr) |-> st.view == V_SET)
        else $error("press in station view did not show settings");

    a_view_cause: assert property (
        st.view != $past(st.view)
        |-> $rose(st.btn_stable) || $past(exit_wr))
        else $error("view changed without debounced press");

    // Channel 1 settings, its own or borrowed from channel 0
    a_set_ch1: assert property (
        st.view == V_SET && !st.mode.interlock
        |-> st.led[14:8] == st.cfg[1][6:0])
        else $error("settings lamps wrong for channel 1");

    a_ilk_follow: assert property (
        st.view == V_SET && st.mode.interlock
        |-> st.led[14:8] == st.cfg[0][6:0])
        else $error("channel 1 lamps not following channel 0");

    // A disabled channel never shows as running
    a_ilk_run8: assert property (
        st.view == V_NORM && !st.mode.ch1_en |-> !st.led[8])
        else $error("channel 1 run lamp lit while disabled");

    a_nak_lamp: assert property (
        st.view == V_NORM && chan_in[1].nak
        ##1 st.view == V_NORM |-> !st.led[11] && st.led[12])
        else $error("nak lamp not set after negative acknowledge");

    // Lamps lag their inputs by one edge; skip the edge after reset
    a_link_lamps: assert property (
        st.view == V_NORM && $past(presetn)
        |-> st.led[2:0] == $past({chan_in[0].rx, chan_in[0].tx,
                                  chan_in[0].run})
            && st.led[10:9] == $past({chan_in[1].rx, chan_in[1].tx}))
        else $error("run, transmit or receive lamp wrong");

    a_idle_lamps: assert property (
        st.view == V_NORM && $past(presetn)
        && !$past(host_link_activity) && !$past(serious_fault)
        |-> !st.led[7] && !st.led[15])
        else $error("flash lamp lit without its cause");

    a_aux_lamps: assert property (
        st.view == V_NORM |-> st.led[6] == st.cfg[0].aux
                              && st.led[14] == st.cfg[1].aux)
        else $error("modem or RS-485 lamp wrong");

    c_settings: cover property (st.view == V_SET);
    c_ilk_set:  cover property (st.view == V_SET && st.mode.interlock);
    c_back_stn: cover property (st.view == V_SET ##[1:1000]
                                st.view == V_STN);
    c_loopback: cover property (st.mode.loopback);
    c_bus_err:  cover property (st.pslverr && st.pready);
endmodule
`default_nettype wire

// file: testbench/sdm_panel_model.sv
// Front panel model: display push-button with contact chatter, mode switch
`default_nettype none
module sdm_panel_model (
    input  wire logic       pclk,
    output var  logic       disp_btn,
    output var  logic [3:0] mode_sw_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Button released and switch at code 0 from time zero
    initial begin
        disp_btn   = 1'b0;
        mode_sw_in = 4'h0;
    end

    // Operator turns the rotary switch; only honoured across a reset
    task automatic set_switch(input logic [3:0] v);
        @(posedge pclk);
        mode_sw_in <= v;
    endtask

    // Contact chatter first, one-cycle runs so no run outlasts debounce
    task automatic move(input logic lvl, input int bounce, input int hold);
        for (int i = 0; i < bounce; i++) begin
            @(posedge pclk);
            disp_btn <= (i % 2 == 0) ? lvl : ~lvl;
        end
        // Settled contact
        repeat (hold) begin
            @(posedge pclk);
            disp_btn <= lvl;
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/status_display_mode_select_test.sv
// Self-checking bench of the status display and mode select block
`default_nettype none
module status_display_mode_select_test
    import sdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic               pclk, presetn, psel, penable, pwrite;
    logic        [11:0] paddr;
    logic        [31:0] pwdata, prdata, rd, cfg0, cfg1;
    logic               pready, pslverr, err, host_link_activity;
    logic               serious_fault, disp_btn;
    sdm_chan_in_t [1:0] chan_in;
    logic         [3:0] mode_sw_in;
    logic        [15:0] led;
    sdm_mode_t          mode;
    logic         [1:0] ack_s, nak_s;       // Lamp state the bench expects
    int                 fail_count, n_checks, seed, cycles, c7, c15;

    // Short flash and debounce counts keep the run brief
    sdm_status_display #(.FLASH_CYC(24'h000004), .DEB_CYC(24'h000003)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
        .host_link_activity(host_link_activity),
        .serious_fault(serious_fault), .disp_btn(disp_btn),
        .mode_sw_in(mode_sw_in), .led(led), .mode(mode));
    sdm_panel_model panel (
        .pclk(pclk), .disp_btn(disp_btn), .mode_sw_in(mode_sw_in));

    // 50 MHz clock
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    // Hang guard: ceiling well above the several hundred cycles needed
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            summarize();
        end
    end

    // Verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Word and lamp comparisons
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Decoded mode comparison
    task automatic chk_mode(input sdm_mode_t exp, input sdm_mode_t got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value mode expected %h seen %h", exp, got);
        end
    endtask

    // Let n edges pass, then look once outputs have settled
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One APB transfer; the request stands until pready is seen high or 40 access cycles pass
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready wait", 32'h1, 32'(pready === 1'b1));
    endtask

    // Reset with the switch already in place
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        ack_s = 2'b00;
        nak_s = 2'b00;
    endtask

    // One acknowledge or negative acknowledge pulse on a channel
    task automatic pulse(input int c, input logic is_ack);
        @(posedge pclk);
        if (is_ack) begin
            chan_in[c].ack <= 1'b1;
        end else begin
            chan_in[c].nak <= 1'b1;
        end
        @(posedge pclk);
        chan_in[c].ack <= 1'b0;
        chan_in[c].nak <= 1'b0;
        ack_s[c] = is_ack;
        nak_s[c] = !is_ack;
    endtask

    // Expected decode of switch codes 0 to 8
    function automatic sdm_mode_t mode_tab(input int s);
        logic [6:0] t [9] = '{7'h04, 7'h2c, 7'h01, 7'h29, 7'h09,
                              7'h21, 7'h41, 7'h49, 7'h7b};
        return sdm_mode_t'(t[s]);
    endfunction

    // Normal view lamps with flashing inputs idle
    function automatic logic [15:0] exp_norm();
        logic [15:0] e;
        for (int c = 0; c < 2; c++) begin
            e[c*8 +: 8] = {1'b0, (c == 1) ? cfg1[7] : cfg0[7],
                chan_in[c].proto_err | chan_in[c].serial_io_fault,
                nak_s[c], ack_s[c], chan_in[c].rx, chan_in[c].tx,
                chan_in[c].run};
        end
        return e;
    endfunction

    // Station and settings views
    function automatic logic [15:0] exp_stn();
        return {2'b11, 1'b0, cfg1[12:8], 3'b000, cfg0[12:8]};
    endfunction
    function automatic logic [15:0] exp_set();
        return {1'b0, cfg1[6:0], 1'b0, cfg0[6:0]};
    endfunction

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        {host_link_activity, serious_fault} = 2'b00;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        chan_in = 14'h0000;
        seed    = 94278;
        cfg0    = 32'h0;
        cfg1    = 32'h0;
        // Switch codes 0 to 8, captured at release of reset
        for (int s = 0; s <= 8; s++) begin
            panel.set_switch(4'(s));
            do_reset();
            settle(2);
            chk_mode(mode_tab(s), mode);
        end
        panel.set_switch(4'h4);
        do_reset();
        panel.set_switch(4'h8);
        settle(3);
        chk_mode(mode_tab(4), mode);
        apb(1'b0, SDM_CFG0_OFS, 32'h0);
        chk("cfg0 reset", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        // Corner station numbers 1f and 0, random settings
        cfg0 = 32'h1f00 | (32'($random(seed)) & 32'hff);
        cfg1 = 32'($random(seed)) & 32'hff;
        apb(1'b1, SDM_CFG0_OFS, cfg0);
        apb(1'b1, SDM_CFG1_OFS, cfg1);
        apb(1'b0, SDM_CFG1_OFS, 32'h0);
        chk("cfg1 readback", cfg1, rd);
        // Random activity and error levels, normal view
        repeat (12) begin
            @(posedge pclk);
            chan_in <= 14'($random(seed)) & 14'h39f3;
            settle(2);
            chk("led normal", exp_norm(), led);
        end
        repeat (8) begin
            pulse($random(seed) & 1, 1'($random(seed)));
            settle(1);
            chk("led ack nak", exp_norm(), led);
        end
        // Flashing lamps
        @(posedge pclk);
        host_link_activity <= 1'b1;
        serious_fault      <= 1'b1;
        for (int on = 1; on >= 0; on--) begin
            settle(2);
            c7  = 0;
            c15 = 0;
            repeat (24) begin
                settle(1);
                c7  += (led[7] === 1'b1);
                c15 += (led[15] === 1'b1);
            end
            chk("led7 flash", 32'(on), 32'(c7 > 4 && c7 < 20));
            chk("led15 flash", 32'(on), 32'(c15 > 4 && c15 < 20));
            @(posedge pclk);
            host_link_activity <= 1'b0;
            serious_fault      <= 1'b0;
        end
        // Status word keeps the switch captured at the last reset
        apb(1'b1, SDM_STAT_OFS, 32'hffffffff);
        apb(1'b0, SDM_STAT_OFS, 32'h0);
        chk("status", {6'h00, 3'b100, 4'h4, 3'h1, exp_norm()}, rd);
        // A press shorter than debounce is refused
        panel.move(1'b1, 0, 2);
        panel.move(1'b0, 0, 6);
        settle(1);
        chk("led glitch", exp_norm(), led);
        panel.move(1'b1, 4, 6);
        settle(1);
        chk("led station", exp_stn(), led);
        panel.move(1'b0, 4, 6);
        settle(1);
        chk("led release", exp_stn(), led);
        panel.move(1'b1, 4, 6);
        settle(1);
        chk("led settings", exp_set(), led);
        // Every baud code on both channels
        for (int b = 0; b < 8; b++) begin
            cfg0 = {cfg0[31:3], 3'(b)};
            cfg1 = {cfg1[31:3], 3'(7 - b)};
            apb(1'b1, SDM_CFG0_OFS, cfg0);
            apb(1'b1, SDM_CFG1_OFS, cfg1);
            settle(2);
            chk("led baud", exp_set(), led);
        end
        panel.move(1'b0, 0, 6);
        panel.move(1'b1, 0, 6);
        settle(1);
        chk("led station again", exp_stn(), led);
        panel.move(1'b0, 0, 6);
        apb(1'b1, SDM_CTRL_OFS, 32'h1);
        settle(2);
        chk("led exit", exp_norm(), led);
        // Interlocked: channel 1 lamps show channel 0 settings
        panel.set_switch(4'h0);
        do_reset();
        apb(1'b1, SDM_CFG0_OFS, cfg0);
        panel.move(1'b1, 0, 6);
        panel.move(1'b0, 0, 6);
        panel.move(1'b1, 0, 6);
        settle(1);
        chk("led ilk", {1'b0, cfg0[6:0], 1'b0, cfg0[6:0]}, led);
        summarize();
    end
endmodule
`default_nettype wire
